// ===== core/option_word_decoder.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// R1: Word0 bit 14 picks RC frequency from option word (0) or register (1).
// R2: Programmer keeps word0 bits 13,10 at one and bits 12,9 at zero.
// R3: Word0 bit 11: 4 clocks per instruction when clear, 2 when set.
// R4: Word0 bits 8:7: 00 off, else 2.7, 3.7, 4.2 V reset.
// R5: Word0 bit 6 set makes shared pin external reset, clear makes it I/O.
// R6: Word0 bit 5 set turns the watchdog on.
// R7: Word0 bit 4: least valid pulse 32 periods when clear, 8 when set.
// R8: Word0 bit 3 clear enables the input pulse filter, set bypasses it.
// R9: Word0 bits 2:0 set enable program memory read-out protection.
// R10: Word1 bit 14: normal speed after reset when clear, green when set.
// R11: Word1 bit 12 set permits the halt function.
// R12: Programmer writes trim bits 11:7; device passes them on unchanged.
// R13: Word1 bits 6:5: 00 4 MHz, 01 16 MHz, 10 8 MHz, 11 reserved.
// R14: Word1 bits 3:1: 100 RC with pin as I/O, 101 RC clock out.
// R15: Word1 bit 0 set makes oscillator pin open drain, clear drives clock.
// R16: Programmer keeps word1 bits 13 and 4 at one.
// R17: Word2 exposes a four-bit field 14:11 and nine-bit ID 8:0.
// R18: All three words load after reset; outputs other than the RC frequency ones then hold until next reset.
module option_word_decoder (
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  // APB slave
  input  wire logic [7:0]                   paddr_i,
  input  wire logic                         psel_i,
  input  wire logic                         penable_i,
  input  wire logic                         pwrite_i,
  input  wire logic [31:0]                  pwdata_i,
  input  wire logic [3:0]                   pstrb_i,
  output logic [31:0]                       prdata_o,
  output logic                              pready_o,
  output logic                              pslverr_o,
  // Option storage read port
  output logic                              nvm_rd_req_o,
  output logic [1:0]                        nvm_rd_addr_o,
  input  wire logic [14:0]                  nvm_rd_data_i,
  input  wire logic                         nvm_rd_ack_i,
  // Load status
  output logic                              options_loaded_o,
  output logic                              option_fixed_bits_bad_o,
  // Clock and instruction timing
  output logic                              rc_freq_source_sel_o,
  output logic                              instr_period_sel_o,
  output logic [2:0]                        instr_clocks_o,
  output option_word_pkg::rc_freq_type      rc_freq_code_o,
  output logic [4:0]                        rc_freq_mhz_o,
  output logic                              rc_freq_reserved_o,
  output logic [4:0]                        rc_trim_value_o,
  output logic [2:0]                        oscillator_mode_code_o,
  output logic                              irc_pin_io_o,
  output logic                              rc_clock_output_o,
  output logic                              osc_out_pin_sel_o,
  output logic                              osc_out_open_drain_o,
  output logic                              osc_out_sys_clock_o,
  // Reset, watchdog and power
  output option_word_pkg::lvr_level_type    low_volt_reset_level_o,
  output logic                              low_volt_reset_on_o,
  output logic                              reset_pin_function_sel_o,
  output logic                              port8_bit3_io_o,
  output logic                              watchdog_on_o,
  output logic                              boot_speed_mode_o,
  output logic                              halt_permit_o,
  // Input noise rejection
  output logic                              glitch_width_sel_o,
  output logic [5:0]                        glitch_min_periods_o,
  output logic                              glitch_filter_off_n_o,
  output logic                              glitch_filter_on_o,
  // Protection and identity
  output logic [2:0]                        code_protect_bits_o,
  output logic                              code_protect_on_o,
  output logic [3:0]                        aux_code_field_o,
  output logic [8:0]                        identification_field_o
);
  import option_word_pkg::*;

  // Whole state of the block
  typedef struct packed {
    load_state_type fsm;
    logic [1:0]     idx;
    logic [14:0]    word0;
    logic [14:0]    word1;
    logic [14:0]    word2;
    options_type    opts;
    logic [1:0]     rc_ctrl;
    rc_freq_type    eff_rc;
    logic [31:0]    rdata;
    logic           slverr;
  } state_type;

  state_type   state_reg;
  state_type   state_next;
  options_type decoded;

  // Addresses that answer without error
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == OFS_WORD0) || (a == OFS_WORD1) ||
                  (a == OFS_WORD2) || (a == OFS_STATUS) ||
                  (a == OFS_RC_CTRL);
  endfunction

  // Field split of the stored words
  option_word_fields u_fields (
    .word0_i (state_reg.word0),
    .word1_i (state_reg.word1),
    .word2_i (state_reg.word2),
    .opts_o  (decoded)
  );

  // Read view of the register map
  function automatic logic [31:0] read_mux(input logic [7:0] a,
                                           input state_type s);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      OFS_WORD0:   v[14:0] = s.word0;
      OFS_WORD1:   v[14:0] = s.word1;
      OFS_WORD2:   v[14:0] = s.word2;
      OFS_STATUS: begin
        v[ST_LOADED_BIT] = (s.fsm == LOAD_READY);
        v[ST_W0_BAD_BIT] = s.opts.w0_bad;
        v[ST_W1_BAD_BIT] = s.opts.w1_bad;
        v[ST_RC_RSV_BIT] = (s.eff_rc == RC_RESERVED);
        v[ST_MHZ_LSB +: 5] = rc_freq_mhz(s.eff_rc);
      end
      OFS_RC_CTRL: v[1:0] = s.rc_ctrl;
      default:     v = 32'h0000_0000;
    endcase
    read_mux = v;
  endfunction

  // Loader, register file and derived state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg.fsm)
      // One idle cycle after reset so storage sees a clean request
      LOAD_START: begin
        state_next.fsm = LOAD_FETCH;
        state_next.idx = NVM_WORD0;
      end
      // Words arrive in order 0, 1, 2, each on its own ack
      LOAD_FETCH: begin
        if (nvm_rd_ack_i) begin
          unique case (state_reg.idx)
            NVM_WORD0: state_next.word0 = nvm_rd_data_i;           // R18
            NVM_WORD1: state_next.word1 = nvm_rd_data_i;           // R18
            default:   state_next.word2 = nvm_rd_data_i;           // R18
          endcase
          if (state_reg.idx == NVM_WORD2) begin
            state_next.fsm = LOAD_LATCH;
          end else begin
            state_next.idx = state_reg.idx + 2'h1;
          end
        end
      end
      // Decoded settings captured once, from the stored words
      LOAD_LATCH: begin
        state_next.opts = decoded;                                 // R18
        state_next.fsm  = LOAD_READY;
      end
      // Settings frozen until the next reset
      LOAD_READY: begin
        state_next.fsm = LOAD_READY;                               // R18
      end
    endcase

    // Taken from the settings being latched, so valid with the loaded flag
    if (state_next.opts.rc_src_reg) begin
      state_next.eff_rc = rc_freq_type'(state_reg.rc_ctrl);        // R1
    end else begin
      state_next.eff_rc = state_next.opts.rc_code;                 // R1
    end

    // Read answer prepared in the setup cycle so it comes from a flop
    if (psel_i && !penable_i) begin
      state_next.rdata  = read_mux(paddr_i, state_reg);
      state_next.slverr = !addr_mapped(paddr_i);
    end

    // Writes land at the access edge; read-only words ignore them
    if (psel_i && penable_i && pwrite_i &&
        (paddr_i == OFS_RC_CTRL) && pstrb_i[0]) begin
      state_next.rc_ctrl = pwdata_i[1:0];
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg         <= '0;
      state_reg.fsm     <= LOAD_START;
      state_reg.idx     <= NVM_WORD0;
      state_reg.opts    <= OPTS_RESET;
      state_reg.rc_ctrl <= RC_CTRL_RESET;
      state_reg.eff_rc  <= RC_4MHZ;
    end else begin
      state_reg <= state_next;
    end
  end

  // APB answers in the first access cycle, never stalls
  assign pready_o  = psel_i & penable_i;
  assign prdata_o  = state_reg.rdata;
  assign pslverr_o = psel_i & penable_i & state_reg.slverr;

  // Storage request held while a word is outstanding
  assign nvm_rd_req_o  = (state_reg.fsm == LOAD_FETCH);
  assign nvm_rd_addr_o = state_reg.idx;

  // Load status
  assign options_loaded_o        = (state_reg.fsm == LOAD_READY);
  // Relies on the programmer holding the unused bits fixed
  assign option_fixed_bits_bad_o = state_reg.opts.w0_bad |
                                   state_reg.opts.w1_bad;  // R2

  // Clock and instruction timing
  assign rc_freq_source_sel_o   = state_reg.opts.rc_src_reg;
  assign instr_period_sel_o     = state_reg.opts.instr_period_sel;
  assign instr_clocks_o         = state_reg.opts.instr_clocks;      // R3
  assign rc_freq_code_o         = state_reg.eff_rc;                 // R13
  // Reserved code reads as zero MHz; the oscillator must not start on it
  assign rc_freq_mhz_o          = rc_freq_mhz(state_reg.eff_rc);    // R13
  assign rc_freq_reserved_o     = (state_reg.eff_rc == RC_RESERVED); // R13
  // Trim is factory data, so it passes through untouched
  assign rc_trim_value_o        = state_reg.opts.trim;              // R12
  assign oscillator_mode_code_o = state_reg.opts.osc_mode;
  assign irc_pin_io_o           = state_reg.opts.irc_pin_io;        // R14
  assign rc_clock_output_o      = state_reg.opts.irc_clk_out;       // R14
  assign osc_out_pin_sel_o      = state_reg.opts.osc_out_pin_sel;
  assign osc_out_open_drain_o   = state_reg.opts.osc_out_pin_sel;   // R15
  assign osc_out_sys_clock_o    = !state_reg.opts.osc_out_pin_sel;  // R15

  // Reset, watchdog and power
  assign low_volt_reset_level_o   = state_reg.opts.lvr_level;       // R4
  assign low_volt_reset_on_o      = (state_reg.opts.lvr_level
                                     != LVR_OFF);                   // R4
  assign reset_pin_function_sel_o = state_reg.opts.reset_pin_sel;   // R5
  assign port8_bit3_io_o          = !state_reg.opts.reset_pin_sel;  // R5
  assign watchdog_on_o            = state_reg.opts.watchdog_on;     // R6
  assign boot_speed_mode_o        = state_reg.opts.boot_speed;      // R10
  assign halt_permit_o            = state_reg.opts.halt_permit;     // R11

  // Input noise rejection
  assign glitch_width_sel_o    = state_reg.opts.glitch_width_sel;
  assign glitch_min_periods_o  = state_reg.opts.glitch_periods;     // R7
  assign glitch_filter_off_n_o = state_reg.opts.glitch_filter_off_n;
  assign glitch_filter_on_o    = !state_reg.opts.glitch_filter_off_n; // R8

  // Protection and identity
  assign code_protect_bits_o    = state_reg.opts.protect;           // R9
  assign code_protect_on_o      = |state_reg.opts.protect;          // R9
  assign aux_code_field_o       = state_reg.opts.aux;               // R17
  assign identification_field_o = state_reg.opts.ident;             // R17

endmodule
`default_nettype wire

// ===== core/option_word_pkg.sv
package option_word_pkg;

  // Option storage geometry
  localparam int unsigned OPT_W      = 15;
  localparam logic [1:0]  NVM_WORD0  = 2'h0;
  localparam logic [1:0]  NVM_WORD1  = 2'h1;
  localparam logic [1:0]  NVM_WORD2  = 2'h2;

  // First option word layout
  localparam int unsigned W0_RC_SRC_BIT     = 14;
  localparam int unsigned W0_INSTR_BIT      = 11;
  localparam int unsigned W0_LVR_HI_BIT     = 8;
  localparam int unsigned W0_LVR_LO_BIT     = 7;
  localparam int unsigned W0_RESET_PIN_BIT  = 6;
  localparam int unsigned W0_WDT_BIT        = 5;
  localparam int unsigned W0_GLITCH_W_BIT   = 4;
  localparam int unsigned W0_GLITCH_OFF_BIT = 3;
  localparam int unsigned W0_PROTECT_LSB    = 0;
  localparam logic [14:0] W0_ONES_MASK      = 15'h2400;
  localparam logic [14:0] W0_ZEROS_MASK     = 15'h1200;

  // Second option word layout
  localparam int unsigned W1_BOOT_SPEED_BIT = 14;
  localparam int unsigned W1_HALT_BIT       = 12;
  localparam int unsigned W1_TRIM_LSB       = 7;
  localparam int unsigned W1_RC_FREQ_LSB    = 5;
  localparam int unsigned W1_OSC_MODE_LSB   = 1;
  localparam int unsigned W1_OSC_PIN_BIT    = 0;
  localparam logic [14:0] W1_ONES_MASK      = 15'h2010;

  // Third option word layout
  localparam int unsigned W2_AUX_LSB        = 11;
  localparam int unsigned W2_ID_LSB         = 0;

  // Oscillator clocks per instruction
  localparam logic [2:0]  INSTR_CLOCKS_SLOW = 3'h4;
  localparam logic [2:0]  INSTR_CLOCKS_FAST = 3'h2;

  // Least accepted pulse, in oscillator periods
  localparam logic [5:0]  GLITCH_PERIODS_WIDE   = 6'h20;
  localparam logic [5:0]  GLITCH_PERIODS_NARROW = 6'h08;

  // Oscillator mode codes with internal RC
  localparam logic [2:0]  OSC_IRC_PIN_IO  = 3'h4;
  localparam logic [2:0]  OSC_IRC_CLK_OUT = 3'h5;

  // Low-voltage reset thresholds
  typedef enum logic [1:0] {
    LVR_OFF = 2'h0,
    LVR_2V7 = 2'h1,
    LVR_3V7 = 2'h2,
    LVR_4V2 = 2'h3
  } lvr_level_type;

  // Internal RC frequency codes
  typedef enum logic [1:0] {
    RC_4MHZ     = 2'h0,
    RC_16MHZ    = 2'h1,
    RC_8MHZ     = 2'h2,
    RC_RESERVED = 2'h3
  } rc_freq_type;

  // Loader sequence, Gray along the path
  typedef enum logic [1:0] {
    LOAD_START = 2'b00,
    LOAD_FETCH = 2'b01,
    LOAD_LATCH = 2'b11,
    LOAD_READY = 2'b10
  } load_state_type;

  // APB register offsets (byte addresses)
  localparam logic [7:0]  OFS_WORD0   = 8'h00;
  localparam logic [7:0]  OFS_WORD1   = 8'h04;
  localparam logic [7:0]  OFS_WORD2   = 8'h08;
  localparam logic [7:0]  OFS_STATUS  = 8'h0c;
  localparam logic [7:0]  OFS_RC_CTRL = 8'h10;

  // Status register fields
  localparam int unsigned ST_LOADED_BIT  = 0;
  localparam int unsigned ST_W0_BAD_BIT  = 1;
  localparam int unsigned ST_W1_BAD_BIT  = 2;
  localparam int unsigned ST_RC_RSV_BIT  = 3;
  localparam int unsigned ST_MHZ_LSB     = 4;
  localparam logic [1:0]  RC_CTRL_RESET  = 2'h0;

  // Decoded option settings
  typedef struct packed {
    logic          rc_src_reg;
    logic          instr_period_sel;
    logic [2:0]    instr_clocks;
    lvr_level_type lvr_level;
    logic          reset_pin_sel;
    logic          watchdog_on;
    logic          glitch_width_sel;
    logic [5:0]    glitch_periods;
    logic          glitch_filter_off_n;
    logic [2:0]    protect;
    logic          boot_speed;
    logic          halt_permit;
    logic [4:0]    trim;
    rc_freq_type   rc_code;
    logic [2:0]    osc_mode;
    logic          irc_pin_io;
    logic          irc_clk_out;
    logic          osc_out_pin_sel;
    logic [3:0]    aux;
    logic [8:0]    ident;
    logic          w0_bad;
    logic          w1_bad;
  } options_type;

  // Safe values until the option words are in
  localparam options_type OPTS_RESET = '{
    instr_clocks   : INSTR_CLOCKS_SLOW,
    lvr_level      : LVR_OFF,
    reset_pin_sel  : 1'b1,
    glitch_periods : GLITCH_PERIODS_WIDE,
    rc_code        : RC_4MHZ,
    default        : '0
  };

  // Frequency in MHz for an RC code, zero when reserved
  function automatic logic [4:0] rc_freq_mhz(input rc_freq_type code);
    unique case (code)
      RC_4MHZ:  rc_freq_mhz = 5'h04;
      RC_16MHZ: rc_freq_mhz = 5'h10;
      RC_8MHZ:  rc_freq_mhz = 5'h08;
      default:  rc_freq_mhz = 5'h00;
    endcase
  endfunction

endpackage

// ===== core/option_word_fields.sv
`timescale 1ns/100ps
`default_nettype none
module option_word_fields (
  // Raw option words
  input  wire logic [14:0]                word0_i,
  input  wire logic [14:0]                word1_i,
  input  wire logic [14:0]                word2_i,
  // Decoded settings
  output option_word_pkg::options_type    opts_o
);
  import option_word_pkg::*;

  // Pure field split and table decode
  always_comb begin
    opts_o                  = OPTS_RESET;
    opts_o.rc_src_reg       = word0_i[W0_RC_SRC_BIT];              // R1
    opts_o.instr_period_sel = word0_i[W0_INSTR_BIT];
    opts_o.instr_clocks     = word0_i[W0_INSTR_BIT] ?
                              INSTR_CLOCKS_FAST : INSTR_CLOCKS_SLOW; // R3
    opts_o.lvr_level        = lvr_level_type'({word0_i[W0_LVR_HI_BIT],
                              word0_i[W0_LVR_LO_BIT]});            // R4
    opts_o.reset_pin_sel    = word0_i[W0_RESET_PIN_BIT];           // R5
    opts_o.watchdog_on      = word0_i[W0_WDT_BIT];                 // R6
    opts_o.glitch_width_sel = word0_i[W0_GLITCH_W_BIT];
    opts_o.glitch_periods   = word0_i[W0_GLITCH_W_BIT] ?
                              GLITCH_PERIODS_NARROW :
                              GLITCH_PERIODS_WIDE;                 // R7
    opts_o.glitch_filter_off_n = word0_i[W0_GLITCH_OFF_BIT];       // R8
    opts_o.protect          = word0_i[W0_PROTECT_LSB +: 3];        // R9
    // Programmer keeps these fixed; a mismatch is only reported
    opts_o.w0_bad = ((word0_i & W0_ONES_MASK) != W0_ONES_MASK) ||
                    ((word0_i & W0_ZEROS_MASK) != 15'h0000);       // R2
    opts_o.w1_bad = ((word1_i & W1_ONES_MASK) != W1_ONES_MASK);    // R16
    opts_o.boot_speed       = word1_i[W1_BOOT_SPEED_BIT];          // R10
    opts_o.halt_permit      = word1_i[W1_HALT_BIT];                // R11
    opts_o.trim             = word1_i[W1_TRIM_LSB +: 5];           // R12
    opts_o.rc_code          = rc_freq_type'(word1_i[W1_RC_FREQ_LSB +: 2]);
    opts_o.osc_mode         = word1_i[W1_OSC_MODE_LSB +: 3];
    opts_o.irc_pin_io  = (word1_i[W1_OSC_MODE_LSB +: 3] ==
                          OSC_IRC_PIN_IO);                         // R14
    opts_o.irc_clk_out = (word1_i[W1_OSC_MODE_LSB +: 3] ==
                          OSC_IRC_CLK_OUT);                        // R14
    opts_o.osc_out_pin_sel  = word1_i[W1_OSC_PIN_BIT];             // R15
    opts_o.aux              = word2_i[W2_AUX_LSB +: 4];            // R17
    opts_o.ident            = word2_i[W2_ID_LSB +: 9];             // R17
  end

endmodule
`default_nettype wire

// ===== verif/option_word_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module option_word_monitor
  import option_word_pkg::*;
(
  // Clock, reset and storage port
  input wire logic          clk_i,
  input wire logic          rst_n_i,
  input wire logic          nvm_rd_req_o,
  input wire logic          nvm_rd_ack_i,
  input wire logic [1:0]    nvm_rd_addr_o,
  // Decoded settings
  input wire logic          options_loaded_o,
  input wire logic          instr_period_sel_o,
  input wire logic [2:0]    instr_clocks_o,
  input wire lvr_level_type low_volt_reset_level_o,
  input wire logic          low_volt_reset_on_o,
  input wire logic          reset_pin_function_sel_o,
  input wire logic          port8_bit3_io_o,
  input wire logic          watchdog_on_o,
  input wire logic          glitch_width_sel_o,
  input wire logic [5:0]    glitch_min_periods_o,
  input wire logic          glitch_filter_off_n_o,
  input wire logic          glitch_filter_on_o,
  input wire logic [2:0]    code_protect_bits_o,
  input wire logic          code_protect_on_o,
  input wire rc_freq_type   rc_freq_code_o,
  input wire logic [4:0]    rc_freq_mhz_o,
  input wire logic [2:0]    oscillator_mode_code_o,
  input wire logic          irc_pin_io_o,
  input wire logic          rc_clock_output_o,
  input wire logic          osc_out_pin_sel_o,
  input wire logic          osc_out_open_drain_o,
  input wire logic          osc_out_sys_clock_o,
  input wire logic [8:0]    identification_field_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Last word taken from storage
  sequence s_last_word;
    nvm_rd_req_o && nvm_rd_ack_i && nvm_rd_addr_o == 2'h2;
  endsequence
  // Settings appear shortly after it, never before
  sequence s_load_after;
    !options_loaded_o ##[2:4] options_loaded_o;
  endsequence
  a_load_after_last: assert property (s_last_word |-> s_load_after)
    else $error("settings not loaded after last word");
  a_hold_frozen: assert property (options_loaded_o |=> options_loaded_o
    && $stable({watchdog_on_o, identification_field_o, instr_clocks_o}))
    else $error("settings moved after load");
  a_instr_count: assert property (options_loaded_o |->
    instr_clocks_o == (instr_period_sel_o ? 3'h2 : 3'h4))
    else $error("instruction clock count wrong");
  a_lvr_enable: assert property (options_loaded_o |->
    low_volt_reset_on_o == (low_volt_reset_level_o != LVR_OFF))
    else $error("low voltage reset enable wrong");
  a_pin_role: assert property (options_loaded_o |->
    port8_bit3_io_o != reset_pin_function_sel_o)
    else $error("shared pin role wrong");
  a_glitch_span: assert property (options_loaded_o |->
    glitch_min_periods_o == (glitch_width_sel_o ? 6'h08 : 6'h20))
    else $error("glitch width wrong");
  a_filter_polarity: assert property (options_loaded_o |->
    glitch_filter_on_o != glitch_filter_off_n_o)
    else $error("filter polarity wrong");
  a_protect_any: assert property (options_loaded_o |->
    code_protect_on_o == (|code_protect_bits_o))
    else $error("protection flag wrong");
  a_rc_freq_map: assert property (options_loaded_o |->
    rc_freq_mhz_o == (rc_freq_code_o == RC_4MHZ ? 5'h04 :
    rc_freq_code_o == RC_16MHZ ? 5'h10 :
    rc_freq_code_o == RC_8MHZ ? 5'h08 : 5'h00))
    else $error("rc frequency wrong");
  a_osc_mode_flags: assert property (options_loaded_o |->
    irc_pin_io_o == (oscillator_mode_code_o == 3'h4)
    && rc_clock_output_o == (oscillator_mode_code_o == 3'h5))
    else $error("oscillator mode flags wrong");
  a_osc_pin_kind: assert property (options_loaded_o |->
    osc_out_open_drain_o == osc_out_pin_sel_o
    && osc_out_sys_clock_o != osc_out_pin_sel_o)
    else $error("oscillator pin function wrong");
endmodule
bind option_word_decoder option_word_monitor i_mon (.*);
`default_nettype wire

// ===== verif/option_store_model.sv
`timescale 1ns/100ps
`default_nettype none
module option_store_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Read port facing the decoder
  input  wire logic        rd_req_i,
  input  wire logic [1:0]  rd_addr_i,
  output logic [14:0]      rd_data_o,
  output logic             rd_ack_o,
  // Stored words and answer delay
  input  wire logic [44:0] words_i,
  input  wire logic [3:0]  delay_i
);
  logic [3:0] wait_cnt;
  // Answer after delay; data not held outside the ack cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_cnt  <= 4'h0;
      rd_ack_o  <= 1'b0;
      rd_data_o <= 15'h7fff;
    end else if (rd_req_i && !rd_ack_o && wait_cnt == delay_i) begin
      wait_cnt  <= 4'h0;
      rd_ack_o  <= 1'b1;
      rd_data_o <= words_i[rd_addr_i*15 +: 15];
    end else begin
      wait_cnt  <= (rd_req_i && !rd_ack_o) ? wait_cnt + 4'h1 : 4'h0;
      rd_ack_o  <= 1'b0;
      rd_data_o <= ~rd_data_o; // Inverted each cycle, so a stale word returns only on alternate cycles
    end
  end
endmodule
`default_nettype wire

// ===== verif/option_word_decoder_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  n_fail++; $display("[ERR] %s exp %h seen %h", nm, e, g); end end
module option_word_decoder_bench;
  import option_word_pkg::*;
  logic clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic nvm_rd_req_o, nvm_rd_ack_i, options_loaded_o, option_fixed_bits_bad_o;
  logic rc_freq_source_sel_o, instr_period_sel_o, rc_freq_reserved_o, rerr;
  logic irc_pin_io_o, rc_clock_output_o, osc_out_pin_sel_o, bad;
  logic osc_out_open_drain_o, osc_out_sys_clock_o, low_volt_reset_on_o;
  logic reset_pin_function_sel_o, port8_bit3_io_o, watchdog_on_o;
  logic boot_speed_mode_o, halt_permit_o, glitch_width_sel_o;
  logic glitch_filter_off_n_o, glitch_filter_on_o, code_protect_on_o;
  logic [1:0]  nvm_rd_addr_o, rc_reg;
  logic [2:0]  instr_clocks_o, oscillator_mode_code_o, code_protect_bits_o;
  logic [3:0]  pstrb_i, aux_code_field_o, dly;
  logic [4:0]  rc_freq_mhz_o, rc_trim_value_o;
  logic [5:0]  glitch_min_periods_o;
  logic [7:0]  paddr_i;
  logic [8:0]  identification_field_o;
  logic [14:0] nvm_rd_data_i, w0, w1, w2;
  logic [31:0] pwdata_i, prdata_o, rdat;
  logic [31:0] seed = 32'h0000_003e;
  rc_freq_type   rc_freq_code_o;
  lvr_level_type low_volt_reset_level_o;
  int n_fail, n_compared, c, k;
  int mhz_tab [4] = '{4, 16, 8, 0};
  option_word_decoder i_dut (.*);
  option_store_model i_store (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .rd_req_i(nvm_rd_req_o), .rd_addr_i(nvm_rd_addr_o),
    .rd_data_o(nvm_rd_data_i), .rd_ack_o(nvm_rd_ack_i),
    .words_i({w2, w1, w0}), .delay_i(dly));
  // Free running 250 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Xorshift source, fixed start
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic complete_run();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One APB transfer; waits for pready under a bound
  task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_i);
      if (pready_o === 1'b1) break;
    end
    if (k == 50) begin
      n_fail++;
      complete_run();
    end
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // Model of every decoded setting from the stored words
  task automatic check_opts();
    c = w0[14] ? int'(rc_reg) : int'(w1[6:5]);
    `CHK("loaded", 1'b1, options_loaded_o)
    `CHK("fixed_bad", bad, option_fixed_bits_bad_o)
    `CHK("rc_src", w0[14], rc_freq_source_sel_o)
    `CHK("instr", {w0[11], w0[11] ? 3'h2 : 3'h4},
      {instr_period_sel_o, instr_clocks_o})
    `CHK("lvr", {w0[8:7], |w0[8:7]},
      {low_volt_reset_level_o, low_volt_reset_on_o})
    `CHK("pin", {w0[6], ~w0[6]},
      {reset_pin_function_sel_o, port8_bit3_io_o})
    `CHK("wdt", w0[5], watchdog_on_o)
    `CHK("glitch", {w0[4], w0[4] ? 6'h08 : 6'h20},
      {glitch_width_sel_o, glitch_min_periods_o})
    `CHK("filter", {w0[3], ~w0[3]},
      {glitch_filter_off_n_o, glitch_filter_on_o})
    `CHK("protect", {w0[2:0], |w0[2:0]},
      {code_protect_bits_o, code_protect_on_o})
    `CHK("boot", w1[14], boot_speed_mode_o)
    `CHK("halt", w1[12], halt_permit_o)
    `CHK("trim", w1[11:7], rc_trim_value_o)
    `CHK("rc", {2'(c), 5'(mhz_tab[c]), c == 3},
      {rc_freq_code_o, rc_freq_mhz_o, rc_freq_reserved_o})
    `CHK("osc", {w1[3:1], w1[3:1] == 3'h4, w1[3:1] == 3'h5},
      {oscillator_mode_code_o, irc_pin_io_o, rc_clock_output_o})
    `CHK("osc_pin", {w1[0], w1[0], ~w1[0]},
      {osc_out_pin_sel_o, osc_out_open_drain_o, osc_out_sys_clock_o})
    `CHK("word2", {w2[14:11], w2[8:0]},
      {aux_code_field_o, identification_field_o})
  endtask
  // Eight loads: every level, frequency code and source, varied delays
  initial begin
    {rst_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {w0, w1, w2, dly, rc_reg, bad} = '0;
    pstrb_i = 4'hf;
    for (int it = 0; it < 8; it++) begin
      w0 = (15'(rnd()) | 15'h2400) & ~15'h1200;
      w1 = 15'(rnd()) | 15'h2010;
      w2 = 15'(rnd());
      w0[8:7] = 2'(it);
      w1[6:5] = 2'(it);
      w0[14] = it[2];
      if (it < 6) w1[3:1] = {2'b10, it[0]};
      bad = (it == 7);
      if (bad) w1[13] = 1'b0; // Programmer slip, only flagged
      dly = 4'(it);
      rc_reg = 2'h0;
      rst_n_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      `CHK("loaded_rst", 1'b0, options_loaded_o)
      rst_n_i <= 1'b1;
      for (k = 0; k < 300 && options_loaded_o !== 1'b1; k++) @(posedge clk_i);
      if (k == 300) begin
        n_fail++;
        complete_run();
      end
      check_opts();
      // Read-only word stays as loaded even after a write attempt
      apb(1'b1, 8'h00, 32'hffff_ffff);
      apb(1'b0, 8'h00, 32'h0000_0000);
      `CHK("word0", {17'h0_0000, w0}, rdat)
      apb(1'b0, 8'h14, 32'h0000_0000);
      `CHK("unmapped", {1'b1, 32'h0000_0000}, {rerr, rdat})
      // Run-time frequency register takes over only when selected
      apb(1'b1, 8'h10, rnd());
      rc_reg = pwdata_i[1:0];
      repeat (2) @(posedge clk_i);
      check_opts();
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      `CHK("status", {23'h0, 5'(mhz_tab[c]), c == 3, bad, 2'b01}, rdat)
    end
    complete_run();
  end
endmodule
`default_nettype wire
